/* hdl/fmt_consts.vh */
// Constants for the fault mask and offset trim register bank.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef FMT_CONSTS_VH
`define FMT_CONSTS_VH

// Printed offsets are not all multiples of four: kept as indices
`define FMT_IDX_FAULT_STATUS 12'h2c1
`define FMT_IDX_FAULT_MASK 12'h2c2
`define FMT_IDX_LANE_FLAGS 12'h2c4
`define FMT_IDX_CORE0_OFFSET_TRIM 12'h330
`define FMT_IDX_CORE1_OFFSET_TRIM 12'h332
`define FMT_IDX_CORE2_INPUT_A_OFFSET_TRIM 12'h334
`define FMT_IDX_CAL_CTRL 12'h3f0
`define FMT_IDX_IRQ_STATUS 12'h3f1
`define FMT_IDX_IRQ_MASK 12'h3f2

// Reset values
`define FMT_MASK_RST 8'h3f
`define FMT_STATUS_RST 8'h3f
`define FMT_LANE_RST 8'hff
`define FMT_TRIM_RSV_RST 4'h0
`define FMT_IRQ_MASK_RST 3'h7
`define FMT_CAL_RST 3'h0

// Fault status / mask field positions
`define FMT_B_FIFO 5
`define FMT_B_PLL 4
`define FMT_B_LINK 3
`define FMT_B_REALIGN 2
`define FMT_B_CLK 0
// Implemented mask and status bits
`define FMT_FAULT_IMPL 8'h3d

// Calibration control field positions
`define FMT_B_OFFSET_CAL_ENABLE 0
`define FMT_B_BACKGROUND_CAL_ENABLE 1
`define FMT_B_BACKGROUND_OFFSET_CAL_ENABLE 2
`define FMT_B_CAL_BUSY 3

// Interrupt status bit positions
`define FMT_I_SUMMARY 0
`define FMT_I_LANE 1
`define FMT_I_TRIM_BLOCKED 2

`define FMT_TRIM_W 12
`define FMT_LANES 8
`endif

/* hdl/fmt_sync2.v */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input has no relation to CLK_SYS.
`timescale 1ns/1ns
module fmt_sync2 (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Level in and out
    input wire d,
    output reg q
);
    reg meta_r;

    // =====================================================
    // Synchroniser chain; only the second flop is read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* hdl/fmt_trim_reg.v */
// One 12-bit offset trim register with reserved upper nibble.
// Assumes the fuse value is stable when fuse_load pulses.
`timescale 1ns/1ns
`include "fmt_consts.vh"
module fmt_trim_reg (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fuse default
    input wire fuse_load,
    input wire [11:0] fuse_val,
    // Software write
    input wire wr_en,
    input wire [15:0] wr_data,
    // Contents
    output reg [15:0] value
);
    // =====================================================
    // Fuse copy wins over a software write in the same cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= 16'h0000;
        end else if (fuse_load) begin
            value <= {`FMT_TRIM_RSV_RST, fuse_val};
        end else if (wr_en) begin
            value <= wr_data;
        end
    end
endmodule

/* hdl/fmt_regs.v */
// Fault mask, lane FIFO error flags and offset trim register bank.
// Assumes an APB master on CLK_SYS; fault and lane events arrive async.
`timescale 1ns/1ns
`include "fmt_consts.vh"
module fmt_regs (
    // Clock and reset
    input wire CLK_SYS,
    input wire RST,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output reg PSLVERR,
    // Fault event inputs (async levels)
    input wire LANE_FIFO_ERR_0,
    input wire LANE_FIFO_ERR_1,
    input wire LANE_FIFO_ERR_2,
    input wire LANE_FIFO_ERR_3,
    input wire LANE_FIFO_ERR_4,
    input wire LANE_FIFO_ERR_5,
    input wire LANE_FIFO_ERR_6,
    input wire LANE_FIFO_ERR_7,
    input wire SERIALIZER_LOCK_FAULT,
    input wire LINK_FAULT,
    input wire REALIGN_FAULT,
    input wire DIVIDER_MISMATCH_FAULT,
    // Calibration state (async)
    input wire FOREGROUND_CAL_DONE,
    input wire OFFSET_CAL_ACTIVE,
    input wire CORE2_INPUT_A_SEL,
    // Fuse defaults
    input wire FUSE_LOAD,
    input wire [11:0] FUSE_CORE0_OFFSET_TRIM,
    input wire [11:0] FUSE_CORE1_OFFSET_TRIM,
    input wire [11:0] FUSE_CORE2_INPUT_A_OFFSET_TRIM,
    // Outputs to the converter
    output reg [11:0] CORE0_OFFSET,
    output reg [11:0] CORE1_OFFSET,
    output reg [11:0] CORE2_OFFSET,
    output reg CORE2_OFFSET_VALID,
    output reg SUMMARY_FAULT,
    output reg [2:0] CAL_CTRL,
    output wire IRQ
);
    // =====================================================
    // Synchronised inputs
    wire [7:0] lane_async;
    wire [14:0] async_in;
    wire [14:0] sync_in;
    wire [7:0] lane_err;
    wire pll_f;
    wire link_f;
    wire realign_f;
    wire clk_f;
    wire foreground_cal_done;
    wire cal_busy;
    wire core2_a;
    genvar gi;

    assign lane_async = {LANE_FIFO_ERR_7, LANE_FIFO_ERR_6, LANE_FIFO_ERR_5,
                         LANE_FIFO_ERR_4, LANE_FIFO_ERR_3, LANE_FIFO_ERR_2,
                         LANE_FIFO_ERR_1, LANE_FIFO_ERR_0};
    assign async_in = {CORE2_INPUT_A_SEL, OFFSET_CAL_ACTIVE, FOREGROUND_CAL_DONE,
                       DIVIDER_MISMATCH_FAULT, REALIGN_FAULT, LINK_FAULT,
                       SERIALIZER_LOCK_FAULT, lane_async};

    generate
        for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
            fmt_sync2 u_sync (
                .clk(CLK_SYS),
                .rst(RST),
                .d(async_in[gi]),
                .q(sync_in[gi])
            );
        end
    endgenerate

    assign lane_err = sync_in[7:0];
    assign pll_f = sync_in[8];
    assign link_f = sync_in[9];
    assign realign_f = sync_in[10];
    assign clk_f = sync_in[11];
    assign foreground_cal_done = sync_in[12];
    assign cal_busy = sync_in[13];
    assign core2_a = sync_in[14];

    // =====================================================
    // APB decode; zero wait states, so PREADY is always high
    wire acc;
    wire wr;
    wire [11:0] idx;
    wire hit_sts;
    wire hit_mask;
    wire hit_lane;
    wire hit_t0;
    wire hit_t1;
    wire hit_t2;
    wire hit_cal;
    wire hit_ists;
    wire hit_imsk;
    wire hit_trim;
    wire mapped;
    wire trim_block;
    wire lo_en;
    wire hi_en;

    assign PREADY = 1'b1;
    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign idx = {2'b00, PADDR[11:2]};
    assign hit_sts = (idx == `FMT_IDX_FAULT_STATUS);
    assign hit_mask = (idx == `FMT_IDX_FAULT_MASK);
    assign hit_lane = (idx == `FMT_IDX_LANE_FLAGS);
    assign hit_t0 = (idx == `FMT_IDX_CORE0_OFFSET_TRIM);
    assign hit_t1 = (idx == `FMT_IDX_CORE1_OFFSET_TRIM);
    assign hit_t2 = (idx == `FMT_IDX_CORE2_INPUT_A_OFFSET_TRIM);
    assign hit_cal = (idx == `FMT_IDX_CAL_CTRL);
    assign hit_ists = (idx == `FMT_IDX_IRQ_STATUS);
    assign hit_imsk = (idx == `FMT_IDX_IRQ_MASK);
    assign hit_trim = hit_t0 | hit_t1 | hit_t2;
    assign mapped = hit_sts | hit_mask | hit_lane | hit_trim | hit_cal
                    | hit_ists | hit_imsk;
    assign lo_en = PSTRB[0];
    assign hi_en = PSTRB[1];

    // Trim access is refused while calibration owns the trims
    reg [2:0] cal_r;
    assign trim_block = cal_busy
        | (cal_r[`FMT_B_BACKGROUND_CAL_ENABLE] & cal_r[`FMT_B_BACKGROUND_OFFSET_CAL_ENABLE])
        | (cal_r[`FMT_B_OFFSET_CAL_ENABLE] & ~(cal_r[`FMT_B_BACKGROUND_CAL_ENABLE] & cal_r[`FMT_B_BACKGROUND_OFFSET_CAL_ENABLE])
           & ~foreground_cal_done);

    // =====================================================
    // Fault status, mask and lane flags
    reg [7:0] status_r;
    reg [7:0] status_nxt;
    reg [7:0] mask_r;
    reg [7:0] lane_r;
    reg [7:0] lane_nxt;
    wire [7:0] fault_set;
    wire [7:0] w1c_sts;
    wire [7:0] w1c_lane;
    wire fifo_clr;

    assign fault_set = {2'b00, |lane_err, pll_f, link_f, realign_f, 1'b0, clk_f};
    assign w1c_sts = (wr & hit_sts & lo_en) ? PWDATA[7:0] : 8'h00;
    assign w1c_lane = (wr & hit_lane & lo_en) ? PWDATA[7:0] : 8'h00;
    assign fifo_clr = w1c_sts[`FMT_B_FIFO];

    // Set wins over clear so a fault in the clearing cycle is kept
    always @* begin
        status_nxt = ((status_r & ~w1c_sts) | fault_set) & `FMT_FAULT_IMPL;
        lane_nxt = lane_r & ~w1c_lane;
        if (fifo_clr) begin
            lane_nxt = 8'h00;
        end
        lane_nxt = lane_nxt | lane_err;
    end

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            status_r <= `FMT_STATUS_RST;
            mask_r <= `FMT_MASK_RST;
            lane_r <= `FMT_LANE_RST;
            cal_r <= `FMT_CAL_RST;
        end else begin
            status_r <= status_nxt;
            lane_r <= lane_nxt;
            // Reserved bits are stored as written; software keeps them
            if (wr & hit_mask & lo_en) begin
                mask_r <= PWDATA[7:0];
            end
            if (wr & hit_cal & lo_en) begin
                cal_r <= PWDATA[2:0];
            end
        end
    end

    // =====================================================
    // Summary fault: OR of unmasked implemented status bits
    wire [7:0] unmasked;
    assign unmasked = status_r & ~mask_r & `FMT_FAULT_IMPL;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SUMMARY_FAULT <= 1'b0;
        end else begin
            SUMMARY_FAULT <= |unmasked;
        end
    end

    // =====================================================
    // Offset trim registers
    wire [15:0] t0;
    wire [15:0] t1;
    wire [15:0] t2;
    wire trim_wr;
    wire [15:0] trim_wdata;
    assign trim_wr = wr & ~trim_block & lo_en & hi_en;
    assign trim_wdata = PWDATA[15:0];

    fmt_trim_reg u_t0 (
        .clk(CLK_SYS),
        .rst(RST),
        .fuse_load(FUSE_LOAD),
        .fuse_val(FUSE_CORE0_OFFSET_TRIM),
        .wr_en(trim_wr & hit_t0),
        .wr_data(trim_wdata),
        .value(t0)
    );
    fmt_trim_reg u_t1 (
        .clk(CLK_SYS),
        .rst(RST),
        .fuse_load(FUSE_LOAD),
        .fuse_val(FUSE_CORE1_OFFSET_TRIM),
        .wr_en(trim_wr & hit_t1),
        .wr_data(trim_wdata),
        .value(t1)
    );
    fmt_trim_reg u_t2 (
        .clk(CLK_SYS),
        .rst(RST),
        .fuse_load(FUSE_LOAD),
        .fuse_val(FUSE_CORE2_INPUT_A_OFFSET_TRIM),
        .wr_en(trim_wr & hit_t2),
        .wr_data(trim_wdata),
        .value(t2)
    );

    // Core 2 trim only drives the core while input A is selected
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CORE0_OFFSET <= 12'h000;
            CORE1_OFFSET <= 12'h000;
            CORE2_OFFSET <= 12'h000;
            CORE2_OFFSET_VALID <= 1'b0;
            CAL_CTRL <= 3'h0;
        end else begin
            CORE0_OFFSET <= t0[11:0];
            CORE1_OFFSET <= t1[11:0];
            CORE2_OFFSET <= core2_a ? t2[11:0] : 12'h000;
            CORE2_OFFSET_VALID <= core2_a;
            CAL_CTRL <= cal_r;
        end
    end

    // =====================================================
    // Interrupt status (W1C, set wins) and mask
    reg [2:0] ists_r;
    reg [2:0] imsk_r;
    reg sum_d_r;
    wire [2:0] iev;
    wire [2:0] iclr;
    wire blocked_acc;
    assign blocked_acc = acc & hit_trim & trim_block;
    assign iev = {blocked_acc, |lane_err, SUMMARY_FAULT & ~sum_d_r};
    assign iclr = (wr & hit_ists & lo_en) ? PWDATA[2:0] : 3'h0;
    assign IRQ = |(ists_r & imsk_r);

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ists_r <= 3'h0;
            imsk_r <= `FMT_IRQ_MASK_RST;
            sum_d_r <= 1'b0;
        end else begin
            sum_d_r <= SUMMARY_FAULT;
            ists_r <= (ists_r & ~iclr) | iev;
            if (wr & hit_imsk & lo_en) begin
                imsk_r <= PWDATA[2:0];
            end
        end
    end

    // =====================================================
    // Read data and error answer; blocked trim reads return zero
    always @* begin
        PRDATA = 32'h0000_0000;
        PSLVERR = acc & (~mapped | (hit_trim & trim_block));
        if (acc & ~PWRITE) begin
            if (hit_sts) PRDATA = {24'h000000, status_r};
            else if (hit_mask) PRDATA = {24'h000000, mask_r};
            else if (hit_lane) PRDATA = {24'h000000, lane_r};
            else if (hit_t0 & ~trim_block) PRDATA = {16'h0000, t0};
            else if (hit_t1 & ~trim_block) PRDATA = {16'h0000, t1};
            else if (hit_t2 & ~trim_block) PRDATA = {16'h0000, t2};
            else if (hit_cal) PRDATA = {28'h0000000, cal_busy, cal_r};
            else if (hit_ists) PRDATA = {29'h00000000, ists_r};
            else if (hit_imsk) PRDATA = {29'h00000000, imsk_r};
        end
    end
endmodule

/* verification/fmt_regs_properties.sv */
// Port-level assertions for the fault mask and trim register bank.
// Assumes it is bound onto fmt_regs; one clock domain, RST async high.
`timescale 1ns/1ns
// ==========
// Checker
module fmt_regs_properties (
    // Clock and reset
    input wire CLK_SYS,
    input wire RST,
    // APB
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    input wire [31:0] PRDATA,
    input wire PSLVERR,
    // Converter side
    input wire FUSE_LOAD,
    input wire [11:0] FUSE_CORE0_OFFSET_TRIM,
    input wire [11:0] CORE0_OFFSET,
    input wire [11:0] CORE2_OFFSET,
    input wire CORE2_OFFSET_VALID,
    input wire SUMMARY_FAULT,
    input wire [2:0] CAL_CTRL
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Access phase and trim 0 qualifiers; fuse load wins over a write
    wire acc = PSEL && PENABLE;
    wire t0 = acc && PADDR == 12'hcc0;
    wire t0w = t0 && PWRITE && PSTRB[1:0] == 2'h3 && !FUSE_LOAD;
    a_mask_reset: assert property ($fell(RST) |-> (!SUMMARY_FAULT) [*2])
        else $error("summary fault raised right after reset");
    // The trim lands at the access edge and reaches the core output one edge later
    a_trim_write: assert property (t0w && !PSLVERR |-> ##2 CORE0_OFFSET == $past(PWDATA[11:0], 2))
        else $error("accepted trim write not applied");
    a_fuse_load: assert property (FUSE_LOAD |-> ##2 CORE0_OFFSET == $past(FUSE_CORE0_OFFSET_TRIM, 2))
        else $error("fuse default not loaded");
    a_blocked_hold: assert property (t0w && PSLVERR |=> ##1 $stable(CORE0_OFFSET))
        else $error("refused trim write changed the trim");
    a_bg_refuse: assert property (t0 && CAL_CTRL[2:1] == 2'h3 |-> PSLVERR && PRDATA == 32'h0)
        else $error("trim access allowed in full background mode");
    a_core2_gate: assert property ((!CORE2_OFFSET_VALID) [*2] |-> CORE2_OFFSET == 12'h0)
        else $error("core 2 trim applied without input A");
    a_mask_hides: assert property (acc && PWRITE && PSTRB[0] && PADDR == 12'hb08 &&
        (PWDATA[5:0] & 6'h3d) == 6'h3d |-> ##2 !SUMMARY_FAULT)
        else $error("fully masked sources still raise summary");
    a_idle_quiet: assert property (!acc |-> PRDATA == 32'h0 && !PSLVERR)
        else $error("read data or error outside access phase");
endmodule

bind fmt_regs fmt_regs_properties u_props (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .FUSE_LOAD(FUSE_LOAD), .FUSE_CORE0_OFFSET_TRIM(FUSE_CORE0_OFFSET_TRIM),
    .CORE0_OFFSET(CORE0_OFFSET), .CORE2_OFFSET(CORE2_OFFSET),
    .CORE2_OFFSET_VALID(CORE2_OFFSET_VALID), .SUMMARY_FAULT(SUMMARY_FAULT),
    .CAL_CTRL(CAL_CTRL));

/* verification/fmt_regs_bench.sv */
// Self-checking bench for the fault mask and offset trim bank.
// Assumes fmt_regs with its bound checker; all traffic over APB.
`timescale 1ns/1ns
module fmt_regs_bench;
    // ==========
    // Signals
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fl = 0, done = 0, act = 0, asel = 0;
    logic [11:0] pa = 0, cur = 12'habc, f0 = 12'h5a5, f1 = 12'h3c3, f2 = 12'h0f0;
    logic [31:0] pwd = 0, q;
    logic [7:0] lane = 0;
    logic [4:0] flt = 0;
    logic e;
    // Calibration cases: ctrl[2:0], done, active, refused
    logic [5:0] tb [8] = '{6'h03, 6'h09, 6'h0c, 6'h19, 6'h1c, 6'h35, 6'h3d, 6'h10};
    wire prdy, perr, sf, irq, c2v;
    wire [31:0] prd;
    wire [11:0] c0, c1, c2;
    wire [2:0] cal;
    int n_fail = 0, num_checks = 0;
    // Byte strobes tied full: every register is written as a whole word
    fmt_regs dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr),
        .LANE_FIFO_ERR_0(lane[0]), .LANE_FIFO_ERR_1(lane[1]), .LANE_FIFO_ERR_2(lane[2]),
        .LANE_FIFO_ERR_3(lane[3]), .LANE_FIFO_ERR_4(lane[4]), .LANE_FIFO_ERR_5(lane[5]),
        .LANE_FIFO_ERR_6(lane[6]), .LANE_FIFO_ERR_7(lane[7]), .SERIALIZER_LOCK_FAULT(flt[4]),
        .LINK_FAULT(flt[3]), .REALIGN_FAULT(flt[2]), .DIVIDER_MISMATCH_FAULT(flt[0]),
        .FOREGROUND_CAL_DONE(done), .OFFSET_CAL_ACTIVE(act), .CORE2_INPUT_A_SEL(asel),
        .FUSE_LOAD(fl), .FUSE_CORE0_OFFSET_TRIM(f0), .FUSE_CORE1_OFFSET_TRIM(f1), .FUSE_CORE2_INPUT_A_OFFSET_TRIM(f2), .CORE0_OFFSET(c0),
        .CORE1_OFFSET(c1), .CORE2_OFFSET(c2), .CORE2_OFFSET_VALID(c2v), .SUMMARY_FAULT(sf),
        .CAL_CTRL(cal), .IRQ(irq));
    // Clock
    initial forever #5 clk = ~clk;
    // ==========
    // Tasks
    task chk(input logic [31:0] g, input logic [31:0] x);
        begin
            num_checks++;
            if (g !== x) begin
                n_fail++;
                $display("MISMATCH %0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    // One APB transfer by register index; held until PREADY at an edge
    task xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
        begin
            @(posedge clk);
            psel <= 1;
            pwr <= w;
            pa <= {i[9:0], 2'b00};
            pwd <= d;
            @(posedge clk);
            pen <= 1;
            // Only the watchdog ends a wait for the answer
            @(posedge clk);
            while (prdy !== 1'b1)
                @(posedge clk);
            q = prd;
            e = perr;
            psel <= 0;
            pen <= 0;
        end
    endtask
    task rd(input logic [11:0] i, input logic [31:0] x);
        begin
            xfer(0, i, 32'h0);
            chk(q, x);
        end
    endtask
    // Events held long enough to cross the input synchronisers
    task pulse(input logic [4:0] f, input logic [7:0] l);
        begin
            @(posedge clk);
            flt <= f;
            lane <= l;
            repeat (4) @(posedge clk);
            flt <= 5'h0;
            lane <= 8'h0;
            repeat (4) @(posedge clk);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        rd(12'h2c1, 32'h3d);
        rd(12'h2c2, 32'h3f);
        rd(12'h2c4, 32'hff);
        rd(12'h330, 32'h0);
        // Each fault source alone, unmasked then masked again
        for (int b = 0; b < 6; b++) if (b != 1) begin
            xfer(1, 12'h2c2, 32'h3f);
            xfer(1, 12'h2c1, 32'h3d);
            if (b == 5) pulse(5'h0, 8'h08);
            else pulse(5'h1 << b, 8'h0);
            rd(12'h2c1, 32'h1 << b);
            xfer(1, 12'h2c2, 32'h3f & ~(32'h1 << b));
            repeat (3) @(posedge clk);
            chk(32'(sf), 32'h1);
            xfer(1, 12'h2c2, 32'h3f);
            repeat (3) @(posedge clk);
            chk(32'(sf), 32'h0);
        end
        rd(12'h2c4, 32'h08);
        xfer(1, 12'h2c4, 32'h08);
        rd(12'h2c4, 32'h0);
        // A lane still in error sets its flag again right after the clear
        lane <= 8'h42;
        repeat (4) @(posedge clk);
        lane <= 8'h02;
        repeat (4) @(posedge clk);
        xfer(1, 12'h2c4, 32'h42);
        rd(12'h2c4, 32'h02);
        lane <= 8'h0;
        repeat (4) @(posedge clk);
        xfer(1, 12'h2c1, 32'h20);
        rd(12'h2c4, 32'h0);
        // Interrupt: cleared, masked, raised, unmasked, cleared
        xfer(1, 12'h3f1, 32'h7);
        xfer(1, 12'h3f2, 32'h0);
        pulse(5'h0, 8'h01);
        chk(32'(irq), 32'h0);
        rd(12'h3f1, 32'h2);
        xfer(1, 12'h3f2, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        xfer(1, 12'h3f1, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // Trims with calibration idle; core 2 follows the input select
        xfer(1, 12'h330, 32'habc);
        xfer(1, 12'h332, 32'h123);
        xfer(1, 12'h334, 32'hfed);
        rd(12'h332, 32'h123);
        chk(32'(c0), 32'habc);
        chk(32'(c2), 32'h0);
        chk(32'(c2v), 32'h0);
        asel <= 1;
        repeat (5) @(posedge clk);
        chk(32'(c2), 32'hfed);
        chk(32'(c2v), 32'h1);
        // Trim access across calibration settings
        for (int i = 0; i < 8; i++) begin
            done <= tb[i][2];
            act <= tb[i][1];
            xfer(1, 12'h3f0, 32'(tb[i][5:3]));
            repeat (4) @(posedge clk);
            chk(32'(cal), 32'(tb[i][5:3]));
            xfer(1, 12'h330, 32'h100 + i);
            chk(32'(e), 32'(tb[i][0]));
            if (!tb[i][0]) cur = 12'(12'h100 + i);
            rd(12'h330, tb[i][0] ? 32'h0 : 32'(cur));
            chk(32'(c0), 32'(cur));
        end
        // Refused trim accesses leave their interrupt status bit behind
        rd(12'h3f1, 32'h4);
        // Fuse defaults replace the trims on a load pulse
        fl <= 1;
        @(posedge clk);
        fl <= 0;
        repeat (2) @(posedge clk);
        chk(32'(c1), 32'(f1));
        rd(12'h330, 32'(f0));
        // Unmapped index answers with an error and zero data
        xfer(0, 12'h001, 32'h0);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        // Second reset in mid-run
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(12'h2c2, 32'h3f);
        rd(12'h2c4, 32'hff);
        results;
    end
    // Watchdog: the sequence needs a few hundred cycles
    initial begin
        #100000;
        n_fail++;
        results;
    end
endmodule
